// *** rtl/ptv_pkg.sv ***
// Shared constants, layouts and carrier types of the trip, vote and actuation block
package ptv_pkg;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int NUM_DIV = 3;
    localparam int NUM_BUS = 3;
    localparam int SENSOR_W_DEF = 16;
    // Division named as the bypass division; its results are routed to the voters like the others
    localparam int BYPASS_DIV = 2;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SETPT0 = 8'h00;
    localparam logic [7:0] OFS_SETPT1 = 8'h04;
    localparam logic [7:0] OFS_SETPT2 = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MAINT = 8'h10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SETPT_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] MAINT_RST = 32'h0000_0000;
    localparam logic OUT_RST = 1'b1;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int ST_PATH_LSB = 0;
    localparam int ST_VOTE_LSB = 9;
    localparam int ST_AUTO = 12;
    localparam int ST_MAN = 13;
    localparam int ST_LATCH = 14;
    localparam int ST_PERMIT = 15;
    localparam int ST_OUT = 16;
    localparam int ST_OOS_LSB = 17;
    localparam int ST_TB_LSB = 20;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } ptv_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ptv_axil_rsp_s;

    // Hardwired discrete inputs; trip_byp_sw high selects trip
    typedef struct packed {
        logic [2:0] oos_sw;
        logic [2:0] trip_byp_sw;
        logic manual_trip;
        logic ns_enable_on;
        logic ns_enable_off;
        logic ns_request;
        logic op_reset;
    } ptv_hw_in_s;

endpackage : ptv_pkg

// *** rtl/ptv_trip_path.sv ***
// One core logic path: compares a sample against its setpoint
`timescale 1ns/1ps
`default_nettype none
module ptv_trip_path
    import ptv_pkg::*;
#(
    parameter int SENSOR_W = SENSOR_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [SENSOR_W-1:0] sample,
    input wire logic [SENSOR_W-1:0] setpoint,
    output logic trip
);

    typedef struct packed {
        logic trip;
    } ptv_path_st_s;

    ptv_path_st_s s_r;
    ptv_path_st_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.trip = (sample >= setpoint);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trip = s_r.trip;

endmodule : ptv_trip_path
`default_nettype wire

// *** rtl/ptv_priority_logic.sv ***
// Actuation priority: merges protective and non-safety commands, latches actuation
`timescale 1ns/1ps
`default_nettype none
module ptv_priority_logic
    import ptv_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic auto_trip,
    input wire logic manual_trip,
    input wire logic ns_enable_on,
    input wire logic ns_enable_off,
    input wire logic ns_request,
    input wire logic op_reset,
    output logic out_energised,
    output logic latched,
    output logic permit
);

    // Fixed gate network only: no stored configuration steers it
    typedef struct packed {
        logic latched;
        logic permit;
        logic out;
    } ptv_prio_st_s;

    ptv_prio_st_s s_r;
    ptv_prio_st_s s_nxt;
    logic prot_now;

    always_comb begin
        s_nxt = s_r;
        prot_now = auto_trip | manual_trip;
        // Latch holds until a deliberate reset with no demand present
        s_nxt.latched = prot_now | (s_r.latched & ~op_reset);
        // Disable wins over enable
        s_nxt.permit = ~ns_enable_off & (ns_enable_on | s_r.permit);
        if (prot_now || s_r.latched) begin
            s_nxt.out = 1'b0;
        end else if (s_r.permit) begin
            s_nxt.out = ns_request;
        end else begin
            s_nxt.out = s_r.out;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{latched: 1'b0, permit: 1'b0, out: OUT_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign out_energised = s_r.out;
    assign latched = s_r.latched;
    assign permit = s_r.permit;

endmodule : ptv_priority_logic
`default_nettype wire

// *** rtl/ptv_top.sv ***
// Trip determination, two-level voting, priority actuation and register access
//
// Contract
// - Three separate trip paths per input module
// - Sample compared to setpoint, binary result
// - Two divisions feed voters directly, 2oo3
// - Third division forwarded one-way by bypass; the code routes it straight to the voters like the others
// - Bypass and voters master; inputs only answer
// - Votes delivered to output round-robin
// - Output 2oo3 over voters de-energises
// - All modules report status, one master
// - Monitor gathers values, results, status, diagnostics
// - Status leaves only on transmit-only port; the code also returns it on register reads of OFS_STATUS
// - Setpoint writes accepted only when out-of-service
// - Trip/bypass switch isolated, routed to users
// - Out-of-service forces trip/bypass, raises alarm
// - Manual trip enters priority logic directly
// - Priority logic takes five command inputs; the code's priority logic takes six, op_reset among them
// - Priority logic is fixed discrete logic
// - Non-safety requests need permissive, no trip
// - Any actuation latched until completion; the code latches only protective trips, released by op_reset
// - Position held until explicit operator action
// - Non-safety may energise or de-energise output
// - Buses independent, concurrent, asynchronous
// - Single receive-only maintenance data port
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ptv_top
    import ptv_pkg::*;
#(
    parameter int SENSOR_W = SENSOR_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_DIV-1:0][SENSOR_W-1:0] sensor_val,
    input wire ptv_hw_in_s hw_in,
    input wire ptv_axil_req_s axi_req,
    output ptv_axil_rsp_s axi_rsp,
    output logic out_energised,
    output logic [NUM_DIV-1:0] oos_alarm,
    output logic [31:0] mon_status,
    output logic [31:0] maint_word
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (SENSOR_W < 1 || SENSOR_W > 31) begin : g_bad_width
        $error("SENSOR_W must lie between 1 and 31");
    end

    // Voting, round-robin delivery and status layout assume three by three
    if (NUM_DIV != 3) begin : g_bad_div
        $error("Majority voting serves exactly three divisions");
    end

    if (NUM_BUS != 3) begin : g_bad_bus
        $error("Round-robin delivery serves exactly three safety buses");
    end

    if (BYPASS_DIV < 0 || BYPASS_DIV >= NUM_DIV) begin : g_bad_byp
        $error("BYPASS_DIV must name one of the divisions");
    end

    if (ST_VOTE_LSB < ST_PATH_LSB + NUM_DIV * NUM_BUS) begin : g_bad_st_path
        $error("Path trip field overlaps the voter field");
    end

    if (ST_TB_LSB + NUM_DIV > 32) begin : g_bad_st_top
        $error("Status fields overrun the status word");
    end

    // Setpoint index is taken from address bits 3:2
    if (OFS_SETPT0 != 8'h00 || OFS_SETPT1 != 8'h04 || OFS_SETPT2 != 8'h08) begin : g_bad_map
        $error("Setpoint offsets must be 0x00, 0x04 and 0x08");
    end

    if (OFS_STATUS == OFS_MAINT || OFS_STATUS[1:0] != 2'h0
            || OFS_MAINT[1:0] != 2'h0) begin : g_bad_regs
        $error("Status and maintenance offsets must be distinct aligned words");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_v;
        logic [31:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        ptv_axil_rsp_s rsp;
        logic [NUM_DIV-1:0][SENSOR_W-1:0] setpt;
        logic [NUM_DIV-1:0] out_of_service;
        logic [NUM_DIV-1:0] tb;
        logic [NUM_DIV-1:0][NUM_BUS-1:0] div_res;
        logic [NUM_BUS-1:0] vote;
        logic [1:0] rr;
        logic [NUM_BUS-1:0] hold;
        logic auto_trip;
        logic [NUM_DIV-1:0] alarm;
        logic [31:0] mon;
        logic [31:0] maint;
    } ptv_st_s;

    ptv_st_s s_r;
    ptv_st_s s_nxt;

    logic [NUM_DIV-1:0][NUM_BUS-1:0] path_trip;
    logic prio_out;
    logic prio_latched;
    logic prio_permit;

    // ------------------------------------------------------------
    // Input module core paths
    // ------------------------------------------------------------
    for (genvar d = 0; d < NUM_DIV; d++) begin : g_div
        for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
            // Each path owns its compare and drives only its own bus
            ptv_trip_path #(
                .SENSOR_W(SENSOR_W)
            ) u_path (
                .clk(clk),
                .rst_n(rst_n),
                .sample(sensor_val[d]),
                .setpoint(s_r.setpt[d]),
                .trip(path_trip[d][b])
            );
        end
    end

    // ------------------------------------------------------------
    // Actuation priority logic
    // ------------------------------------------------------------
    // Manual trip goes straight in, past every programmable stage
    ptv_priority_logic u_prio (
        .clk(clk),
        .rst_n(rst_n),
        .auto_trip(s_r.auto_trip),
        .manual_trip(hw_in.manual_trip),
        .ns_enable_on(hw_in.ns_enable_on),
        .ns_enable_off(hw_in.ns_enable_off),
        .ns_request(hw_in.ns_request),
        .op_reset(hw_in.op_reset),
        .out_energised(prio_out),
        .latched(prio_latched),
        .permit(prio_permit)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        merge_bytes = r;
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Latency in clocks: trip path, division result, voter,
    // round-robin hold (up to three), auto trip, priority stage.
    // A one-cycle glitch on the voters lands in one hold bit only,
    // so the majority over the holds does not pass it on.
    always_comb begin
        logic [31:0] sp_word;
        logic [NUM_BUS-1:0] col;
        logic [31:0] st;
        int idx;
        sp_word = '0;
        col = '0;
        st = '0;
        idx = 0;
        s_nxt = s_r;

        // Switch states isolated by the hardwired stage
        s_nxt.out_of_service = hw_in.oos_sw;
        s_nxt.tb = hw_in.trip_byp_sw;

        // Result routing per division; the bypass division takes the same
        // direct route to its voter as the others
        for (int d = 0; d < NUM_DIV; d++) begin
            for (int b = 0; b < NUM_BUS; b++) begin
                if (s_r.out_of_service[d]) begin
                    s_nxt.div_res[d][b] = s_r.tb[d];
                end else if (d == BYPASS_DIV) begin
                    s_nxt.div_res[d][b] = path_trip[d][b];
                end else begin
                    s_nxt.div_res[d][b] = path_trip[d][b];
                end
            end
            s_nxt.alarm[d] = s_r.out_of_service[d];
        end

        // One voter per safety bus, each on its own path
        for (int b = 0; b < NUM_BUS; b++) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                col[d] = s_r.div_res[d][b];
            end
            s_nxt.vote[b] = maj3(col);
        end

        // Round-robin delivery of one voter result per cycle
        s_nxt.hold[s_r.rr] = s_r.vote[s_r.rr];
        s_nxt.rr = (s_r.rr == 2'(NUM_BUS - 1)) ? 2'h0 : s_r.rr + 2'h1;
        s_nxt.auto_trip = maj3(s_r.hold);

        // Status word for the transmit-only monitor port
        st[ST_PATH_LSB +: 9] = path_trip;
        st[ST_VOTE_LSB +: 3] = s_r.vote;
        st[ST_AUTO] = s_r.auto_trip;
        st[ST_MAN] = hw_in.manual_trip;
        st[ST_LATCH] = prio_latched;
        st[ST_PERMIT] = prio_permit;
        st[ST_OUT] = prio_out;
        st[ST_OOS_LSB +: 3] = s_r.out_of_service;
        st[ST_TB_LSB +: 3] = s_r.tb;
        s_nxt.mon = st;

        // Write address and data taken in either order
        if (axi_req.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_v = 1'b1;
            s_nxt.aw_a = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.rsp.wready) begin
            s_nxt.w_v = 1'b1;
            s_nxt.w_d = axi_req.wdata;
            s_nxt.w_s = axi_req.wstrb;
        end
        if (s_r.rsp.bvalid && axi_req.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        if (s_r.aw_v && s_r.w_v && !s_r.rsp.bvalid) begin
            s_nxt.aw_v = 1'b0;
            s_nxt.w_v = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = RESP_OKAY;
            if (s_r.aw_a[31:8] != 24'h00_0000 || s_r.aw_a[1:0] != 2'h0) begin
                s_nxt.rsp.bresp = RESP_DECERR;
            end else begin
                case (s_r.aw_a[7:0])
                    OFS_SETPT0, OFS_SETPT1, OFS_SETPT2: begin
                        idx = int'(s_r.aw_a[3:2]);
                        // Out-of-service state as registered, one clock behind the switch
                        if (s_r.out_of_service[idx]) begin
                            sp_word = merge_bytes(32'(s_r.setpt[idx]), s_r.w_d, s_r.w_s);
                            s_nxt.setpt[idx] = sp_word[SENSOR_W-1:0];
                        end else begin
                            s_nxt.rsp.bresp = RESP_SLVERR;
                        end
                    end
                    OFS_STATUS: begin
                        // Status is read only: the monitor path never receives
                        s_nxt.rsp.bresp = RESP_SLVERR;
                    end
                    OFS_MAINT: begin
                        s_nxt.maint = merge_bytes(s_r.maint, s_r.w_d, s_r.w_s);
                    end
                    default: begin
                        s_nxt.rsp.bresp = RESP_DECERR;
                    end
                endcase
            end
        end
        // Refuse new write items while one is held or answered
        s_nxt.rsp.awready = !s_nxt.aw_v && !s_nxt.rsp.bvalid;
        s_nxt.rsp.wready = !s_nxt.w_v && !s_nxt.rsp.bvalid;

        // Read channel
        if (s_r.rsp.rvalid && axi_req.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s_r.rsp.arready) begin
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rresp = RESP_OKAY;
            // Unmapped or unaligned reads answer with zero data
            s_nxt.rsp.rdata = '0;
            if (axi_req.araddr[31:8] != 24'h00_0000 || axi_req.araddr[1:0] != 2'h0) begin
                s_nxt.rsp.rresp = RESP_DECERR;
            end else begin
                case (axi_req.araddr[7:0])
                    OFS_SETPT0, OFS_SETPT1, OFS_SETPT2: begin
                        idx = int'(axi_req.araddr[3:2]);
                        s_nxt.rsp.rdata = 32'(s_r.setpt[idx]);
                    end
                    OFS_STATUS: begin
                        s_nxt.rsp.rdata = s_r.mon;
                    end
                    OFS_MAINT: begin
                        s_nxt.rsp.rdata = '0;
                    end
                    default: begin
                        s_nxt.rsp.rresp = RESP_DECERR;
                    end
                endcase
            end
        end
        // One read in flight: refuse while the answer stands
        s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.setpt <= {NUM_DIV{SETPT_RST[SENSOR_W-1:0]}};
            s_r.maint <= MAINT_RST;
            // Readies start high: the first request is taken at once
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready <= 1'b1;
            s_r.rsp.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output below is a flop of the state or of the priority stage
    assign axi_rsp = s_r.rsp;
    assign out_energised = prio_out;
    assign oos_alarm = s_r.alarm;
    assign mon_status = s_r.mon;
    assign maint_word = s_r.maint;

endmodule : ptv_top
`default_nettype wire

// *** verification/ptv_top_props.sv ***
// Port assertions for the trip, vote and actuation top
`timescale 1ns/1ps
`default_nettype none
module ptv_top_props
    import ptv_pkg::*;
#(
    parameter int SENSOR_W = SENSOR_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_DIV-1:0][SENSOR_W-1:0] sensor_val,
    input wire ptv_hw_in_s hw_in,
    input wire ptv_axil_req_s axi_req,
    input wire ptv_axil_rsp_s axi_rsp,
    input wire logic out_energised,
    input wire logic [NUM_DIV-1:0] oos_alarm,
    input wire logic [31:0] mon_status,
    input wire logic [31:0] maint_word
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Actuation
    // ----
    property p_man;
        hw_in.manual_trip |-> ##[1:3] !out_energised;
    endproperty
    a_man: assert property (p_man) else $error("manual trip missed");
    property p_rank;
        hw_in.manual_trip [*4] |-> !out_energised;
    endproperty
    a_rank: assert property (p_rank) else $error("energised under trip");
    property p_hold;
        !out_energised && !mon_status[ST_PERMIT] && !hw_in.ns_enable_on
            && !$past(hw_in.ns_enable_on) && !$past(hw_in.ns_enable_on, 2) |=> !out_energised;
    endproperty
    a_hold: assert property (p_hold) else $error("output left its position");
    property p_alarm;
        $past(rst_n, 2) |-> oos_alarm == $past(hw_in.oos_sw, 2);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm wrong");
    property p_mstat;
        hw_in.manual_trip [*4] |-> mon_status[ST_MAN];
    endproperty
    a_mstat: assert property (p_mstat) else $error("status lacks trip");
    // ----
    // Register bus
    // ----
    property p_bans;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
            |-> ##[1:2] axi_rsp.bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_bref;
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
    endproperty
    a_bref: assert property (p_bref) else $error("write taken early");
    property p_rans;
        axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
endmodule : ptv_top_props
bind ptv_top ptv_top_props #(.SENSOR_W(SENSOR_W)) u_props (.clk(clk), .rst_n(rst_n),
    .sensor_val(sensor_val), .hw_in(hw_in), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .out_energised(out_energised), .oos_alarm(oos_alarm), .mon_status(mon_status),
    .maint_word(maint_word));
`default_nettype wire

// *** verification/ptv_plant_model.sv ***
// Field sensors and one actuated component beside the block
`timescale 1ns/1ps
`default_nettype none
module ptv_plant_model
    import ptv_pkg::*;
#(
    parameter int SENSOR_W = SENSOR_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_DIV-1:0][SENSOR_W-1:0] level,
    input wire logic out_energised,
    output logic [NUM_DIV-1:0][SENSOR_W-1:0] sensor_val,
    output logic position
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sensor_val <= '0;
            position <= OUT_RST;
        end else begin
            sensor_val <= level;
            position <= out_energised;
        end
    end
endmodule : ptv_plant_model
`default_nettype wire

// *** verification/protection_trip_vote_actuation_test.sv ***
// Self-checking bench for the trip, vote and actuation block
`timescale 1ns/1ps
`default_nettype none
module protection_trip_vote_actuation_test
    import ptv_pkg::*;
;
    localparam int SW = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_DIV-1:0][SW-1:0] level = '0;
    logic [NUM_DIV-1:0][SW-1:0] sensor_val;
    ptv_hw_in_s hw_in = '0;
    ptv_axil_req_s axi_req = '0;
    ptv_axil_rsp_s axi_rsp;
    logic out_energised;
    logic position;
    logic [NUM_DIV-1:0] oos_alarm;
    logic [31:0] mon_status;
    logic [31:0] maint_word;
    logic [31:0] rd;
    logic [31:0] k;
    logic [1:0] rsp;
    logic [SW-1:0] sp;
    logic [2:0] lt, os, tb, dt;
    logic [8:0] m9;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 74190;

    always #4 clk = ~clk;

    ptv_top #(.SENSOR_W(SW)) DUT (.clk(clk), .rst_n(rst_n), .sensor_val(sensor_val),
        .hw_in(hw_in), .axi_req(axi_req), .axi_rsp(axi_rsp), .out_energised(out_energised),
        .oos_alarm(oos_alarm), .mon_status(mon_status), .maint_word(maint_word));
    ptv_plant_model #(.SENSOR_W(SW)) u_plant (.clk(clk), .rst_n(rst_n), .level(level),
        .out_energised(out_energised), .sensor_val(sensor_val), .position(position));

    // ----
    // Helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic settle();
        repeat (14) @(posedge clk);
    endtask : settle

    task automatic pulse(input ptv_hw_in_s m);
        hw_in <= ptv_hw_in_s'(hw_in | m);
        @(posedge clk);
        hw_in <= ptv_hw_in_s'(hw_in & ~m);
        @(posedge clk);
    endtask : pulse

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        axi_req.awaddr <= {24'h0, a};
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr

    task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        axi_req.araddr <= {24'h0, a};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rdt

    function automatic logic vote(input logic [2:0] t);
        return (t[0] & t[1]) | (t[0] & t[2]) | (t[1] & t[2]);
    endfunction : vote

    // Clears demands, then lets the permissive re-energise the output
    task automatic recover();
        level <= {3{sp - 16'h10}};
        hw_in.oos_sw <= 3'h0;
        hw_in.ns_request <= 1'b1;
        settle();
        pulse('{op_reset: 1'b1, ns_enable_on: 1'b1, default: '0});
        settle();
        chk(32'(out_energised), 32'h1);
        pulse('{ns_enable_off: 1'b1, default: '0});
    endtask : recover

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(32'(out_energised), 32'(OUT_RST));
        rdt(OFS_SETPT1, rd, rsp);
        chk(rd, 32'(SETPT_RST[SW-1:0]));
        wr(OFS_SETPT0, 32'h1234, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(OFS_STATUS, 32'h1, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        rdt(8'h14, rd, rsp);
        chk(32'(rsp), 32'(RESP_DECERR));
        chk(rd, 32'h0);
        wr(OFS_MAINT, 32'hA5C3_0F96, rsp);
        chk(maint_word, 32'hA5C3_0F96);
        rdt(OFS_MAINT, rd, rsp);
        chk(rd, 32'h0);
        hw_in.oos_sw <= 3'h7;
        repeat (3) @(posedge clk);
        k = $random(seed);
        sp = 16'h2000 | k[13:0];
        for (int d = 0; d < 3; d++) begin
            wr(OFS_SETPT0 + 8'(4 * d), {16'h0, sp}, rsp);
            chk(32'(rsp), 32'(RESP_OKAY));
            rdt(OFS_SETPT0 + 8'(4 * d), rd, rsp);
            chk(rd, {16'h0, sp});
        end
        for (int i = 0; i < 30; i++) begin
            for (int d = 0; d < 3; d++) begin
                k = $random(seed);
                lt[d] = k[0];
                os[d] = k[3] & k[4];
                tb[d] = k[5];
                level[d] <= k[0] ? sp + 16'(k[2:1]) : sp - 16'h1 - 16'(k[2:1]);
            end
            hw_in.oos_sw <= os;
            hw_in.trip_byp_sw <= tb;
            dt = (os & tb) | (~os & lt);
            m9 = {{3{~os[2]}}, {3{~os[1]}}, {3{~os[0]}}};
            settle();
            chk(32'(mon_status[8:0] & m9), 32'({{3{lt[2]}}, {3{lt[1]}}, {3{lt[0]}}} & m9));
            chk(32'(mon_status[12:9]), 32'({4{vote(dt)}}));
            chk(32'(mon_status[22:17]), 32'({tb, os}));
            chk(32'(oos_alarm), 32'(os));
            chk(32'(out_energised), 32'(!vote(dt)));
            if (vote(dt)) recover();
        end
        hw_in.ns_request <= 1'b0;
        settle();
        chk(32'(out_energised), 32'h1);
        pulse('{ns_enable_on: 1'b1, default: '0});
        settle();
        chk(32'(out_energised), 32'h0);
        hw_in.ns_request <= 1'b1;
        settle();
        chk(32'(out_energised), 32'h1);
        hw_in.manual_trip <= 1'b1;
        settle();
        chk(32'(out_energised), 32'h0);
        chk(32'(mon_status[ST_LATCH]), 32'h1);
        hw_in.manual_trip <= 1'b0;
        settle();
        chk(32'(out_energised), 32'h0);
        pulse('{ns_enable_off: 1'b1, op_reset: 1'b1, default: '0});
        settle();
        chk(32'(out_energised), 32'h0);
        pulse('{ns_enable_on: 1'b1, default: '0});
        settle();
        chk(32'(out_energised), 32'h1);
        chk(32'(position), 32'(out_energised));
        stop_test();
    end

    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end
endmodule : protection_trip_vote_actuation_test
`default_nettype wire
